/* File: fidsr_regs.vh */
// constants for the flash id and status read command block
`ifndef FIDSR_REGS_VH
`define FIDSR_REGS_VH
`define FIDSR_OP_ID_READ 8'h9F
`define FIDSR_OP_QUAD_ID_READ 8'hAF
`define FIDSR_OP_PARAM_READ 8'h5A
`define FIDSR_OP_UNIQUE_READ 8'h4B
`define FIDSR_OP_STATUS_ONE 8'h05
`define FIDSR_OP_STATUS_TWO 8'h07
`define FIDSR_OP_RESET_ARM 8'h66
`define FIDSR_OP_RESET_GO 8'h99
`define FIDSR_OP_MODE_EXIT 8'hFF
`define FIDSR_OP_RSV_18 8'h18
`define FIDSR_OP_RSV_41 8'h41
`define FIDSR_OP_RSV_43 8'h43
`define FIDSR_OP_RSV_4A 8'h4A
`define FIDSR_OP_RSV_ED 8'hED
`define FIDSR_OP_RSV_EE 8'hEE
`define FIDSR_UNIQUE_DUMMY_CLKS 6'h20
`define FIDSR_ID_BYTES 4'h3
`define FIDSR_UNIQUE_BYTES 4'h8
`define FIDSR_PARAM_DEPTH 256
`define FIDSR_RESET_CFG_ONE 8'h00
`define FIDSR_RESET_CFG_TWO 8'h00
`define FIDSR_RESET_CFG_THREE 8'h08
`define FIDSR_CFG_ONE_QUAD_BIT 1
`define FIDSR_CFG_TWO_ADDR4_BIT 0
`define FIDSR_CFG_TWO_FOURWIRE_BIT 3
`endif

/* File: fidsr_sync.v */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module fidsr_sync (
  input wire clk,
  input wire rstn,
  input wire clkEn,
  input wire pinIn,
  output reg syncOut
);
  reg s1Q;
  reg s2Q;
  reg s3Q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1Q <= 1'b0;
      s2Q <= 1'b0;
      s3Q <= 1'b0;
      syncOut <= 1'b0;
    end else if (clkEn) begin
      s1Q <= pinIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
      // change counts only when the last two stages agree
      if (s2Q == s3Q) begin
        syncOut <= s3Q;
      end
    end
  end
endmodule // fidsr_sync

/* File: fidsr_core.v */
// flash id, parameter, unique number and status read command interpreter
`timescale 1ns/1ps
`include "fidsr_regs.vh"
module fidsr_core #(
  parameter [7:0] MAKER_ID = 8'h5A,
  parameter [15:0] DEVICE_ID = 16'h1234,
  parameter [63:0] UNIQUE_NUMBER = 64'h0123456789ABCDEF
) (
  input wire clk,
  input wire rstn,
  input wire clkEn,
  input wire csnPin,
  input wire sckPin,
  input wire [3:0] ioIn,
  output reg [3:0] ioOut,
  output reg [3:0] ioOe,
  input wire busy,
  input wire [7:0] volatileStatusOne,
  input wire [7:0] volatileStatusTwo,
  input wire protectBitOneIn,
  input wire lockBitIn,
  input wire cfgWrite,
  input wire [7:0] cfgOneIn,
  input wire [7:0] cfgTwoIn,
  input wire [7:0] cfgThreeIn,
  input wire continuousModeSet,
  output reg [7:0] volatileConfigOne,
  output reg [7:0] volatileConfigTwo,
  output reg [7:0] volatileConfigThree,
  output reg continuousMode,
  output reg softResetPulse,
  output reg protectBitOne,
  output reg lockBit
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire csnSync;
  wire sckSync;
  wire [3:0] ioSync;
  wire [5:0] pinVec;
  wire [5:0] pinSync;
  assign pinVec = {~csnPin, sckPin, ioIn};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : gSync
      fidsr_sync uSync (
        .clk(clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .pinIn(pinVec[gi]),
        .syncOut(pinSync[gi])
      );
    end
  endgenerate
  // chip select inverted so the synchroniser resets to deselected
  assign csnSync = ~pinSync[5];
  assign sckSync = pinSync[4];
  assign ioSync = pinSync[3:0];

  reg sckPrevQ;
  wire sckRise;
  wire sckFall;
  wire selected;
  assign sckRise = sckSync & ~sckPrevQ;
  assign sckFall = ~sckSync & sckPrevQ;
  assign selected = ~csnSync;

  // ****************************************************************
  // parameter table memory
  // ****************************************************************
  reg [7:0] paramMem [0:`FIDSR_PARAM_DEPTH-1];
  integer mi;
  initial begin
    for (mi = 0; mi < `FIDSR_PARAM_DEPTH; mi = mi + 1) begin
      paramMem[mi] = mi[7:0] ^ 8'hA5;
    end
  end

  // ****************************************************************
  // command state machine
  // ****************************************************************
  localparam [2:0] ST_OPCODE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_DUMMY = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_IGNORE = 3'h4;
  localparam [2:0] KIND_ID = 3'h0;
  localparam [2:0] KIND_PARAM = 3'h1;
  localparam [2:0] KIND_UNIQUE = 3'h2;
  localparam [2:0] KIND_STAT1 = 3'h3;
  localparam [2:0] KIND_STAT2 = 3'h4;

  reg [2:0] state_q;
  reg [2:0] kind_q;
  reg [7:0] shift_q;
  reg [5:0] bitCnt_q;
  reg [31:0] addr_q;
  reg [5:0] dummyCnt_q;
  reg [7:0] outByte_q;
  reg [3:0] byteIdx_q;
  reg [2:0] outBit_q;
  reg quadOut_q;
  reg resetArmed_q;

  wire fourWire;
  wire quadMode;
  wire addr4;
  wire [3:0] latency;
  assign fourWire = volatileConfigTwo[`FIDSR_CFG_TWO_FOURWIRE_BIT];
  assign quadMode = volatileConfigOne[`FIDSR_CFG_ONE_QUAD_BIT];
  assign addr4 = volatileConfigTwo[`FIDSR_CFG_TWO_ADDR4_BIT];
  assign latency = volatileConfigThree[3:0];

  // next shift value: four bits per edge in four-wire mode, one on line zero otherwise
  wire [7:0] shiftNext;
  wire [5:0] bitStep;
  assign shiftNext = fourWire ? {shift_q[3:0], ioSync} : {shift_q[6:0], ioSync[0]};
  assign bitStep = fourWire ? 6'h4 : 6'h1;
  wire [5:0] bitsAfter;
  assign bitsAfter = bitCnt_q + bitStep;
  wire [5:0] addrBits;
  assign addrBits = addr4 ? 6'h20 : 6'h18;

  // byte to present for a given kind and index
  function [7:0] pickByte;
    input [2:0] kind;
    input [3:0] idx;
    input [31:0] addr;
    begin
      pickByte = 8'h00;
      case (kind)
        KIND_ID: begin
          case (idx)
            4'h0: pickByte = MAKER_ID;
            4'h1: pickByte = DEVICE_ID[15:8];
            4'h2: pickByte = DEVICE_ID[7:0];
            default: pickByte = 8'h00;
          endcase
        end
        KIND_PARAM: pickByte = paramMem[addr[7:0]];
        KIND_UNIQUE: begin
          if (idx < `FIDSR_UNIQUE_BYTES) begin
            pickByte = UNIQUE_NUMBER[63 - {idx[2:0], 3'h0} -: 8];
          end else begin
            pickByte = 8'h00;
          end
        end
        KIND_STAT1: pickByte = volatileStatusOne;
        KIND_STAT2: pickByte = volatileStatusTwo;
        default: pickByte = 8'h00;
      endcase
    end
  endfunction

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sckPrevQ <= 1'b0;
      state_q <= ST_OPCODE;
      kind_q <= KIND_ID;
      shift_q <= 8'h00;
      bitCnt_q <= 6'h00;
      addr_q <= 32'h00000000;
      dummyCnt_q <= 6'h00;
      outByte_q <= 8'h00;
      byteIdx_q <= 4'h0;
      outBit_q <= 3'h0;
      quadOut_q <= 1'b0;
      resetArmed_q <= 1'b0;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
      volatileConfigOne <= `FIDSR_RESET_CFG_ONE;
      volatileConfigTwo <= `FIDSR_RESET_CFG_TWO;
      volatileConfigThree <= `FIDSR_RESET_CFG_THREE;
      continuousMode <= 1'b0;
      softResetPulse <= 1'b0;
      protectBitOne <= 1'b0;
      lockBit <= 1'b0;
    end else if (clkEn) begin
      sckPrevQ <= sckSync;
      softResetPulse <= 1'b0;
      if (cfgWrite) begin
        volatileConfigOne <= cfgOneIn;
        volatileConfigTwo <= cfgTwoIn;
        volatileConfigThree <= cfgThreeIn;
        protectBitOne <= protectBitOneIn;
        lockBit <= lockBitIn;
      end
      if (!selected) begin
        // deselect ends any command, partial or in output
        state_q <= ST_OPCODE;
        bitCnt_q <= 6'h00;
        ioOe <= 4'h0;
        // a frame cut inside an opcode breaks the arm-then-go pairing
        if (state_q == ST_OPCODE && bitCnt_q != 6'h00) begin
          resetArmed_q <= 1'b0;
        end
      end else begin
        if (sckRise) begin
          case (state_q)
            ST_OPCODE: begin
              shift_q <= shiftNext;
              bitCnt_q <= bitsAfter;
              if (bitsAfter == 6'h08) begin
                bitCnt_q <= 6'h00;
                state_q <= ST_IGNORE;
                quadOut_q <= fourWire;
                byteIdx_q <= 4'h0;
                outBit_q <= 3'h0;
                resetArmed_q <= 1'b0;
                case (shiftNext)
                  `FIDSR_OP_ID_READ: begin
                    if (!busy) begin
                      kind_q <= KIND_ID;
                      outByte_q <= pickByte(KIND_ID, 4'h0, 32'h0);
                      state_q <= ST_DATA;
                    end
                  end
                  `FIDSR_OP_QUAD_ID_READ: begin
                    if ((fourWire || quadMode) && !busy) begin
                      kind_q <= KIND_ID;
                      quadOut_q <= 1'b1;
                      outByte_q <= pickByte(KIND_ID, 4'h0, 32'h0);
                      state_q <= ST_DATA;
                    end
                  end
                  `FIDSR_OP_PARAM_READ: begin
                    kind_q <= KIND_PARAM;
                    addr_q <= 32'h00000000;
                    state_q <= ST_ADDR;
                  end
                  `FIDSR_OP_UNIQUE_READ: begin
                    kind_q <= KIND_UNIQUE;
                    dummyCnt_q <= `FIDSR_UNIQUE_DUMMY_CLKS;
                    state_q <= ST_DUMMY;
                  end
                  `FIDSR_OP_STATUS_ONE: begin
                    kind_q <= KIND_STAT1;
                    outByte_q <= volatileStatusOne;
                    state_q <= ST_DATA;
                  end
                  `FIDSR_OP_STATUS_TWO: begin
                    // four-wire reads of status two go through read-any-register
                    if (!fourWire) begin
                      kind_q <= KIND_STAT2;
                      outByte_q <= volatileStatusTwo;
                      state_q <= ST_DATA;
                    end
                  end
                  `FIDSR_OP_RESET_ARM: begin
                    resetArmed_q <= 1'b1;
                  end
                  `FIDSR_OP_RESET_GO: begin
                    if (resetArmed_q) begin
                      // protect bit one and lock bit deliberately keep their values
                      volatileConfigOne <= `FIDSR_RESET_CFG_ONE;
                      volatileConfigTwo <= `FIDSR_RESET_CFG_TWO;
                      volatileConfigThree <= `FIDSR_RESET_CFG_THREE;
                      continuousMode <= 1'b0;
                      softResetPulse <= 1'b1;
                    end
                  end
                  `FIDSR_OP_MODE_EXIT: begin
                    continuousMode <= 1'b0;
                  end
                  `FIDSR_OP_RSV_18, `FIDSR_OP_RSV_41, `FIDSR_OP_RSV_43,
                  `FIDSR_OP_RSV_4A, `FIDSR_OP_RSV_ED, `FIDSR_OP_RSV_EE: begin
                    state_q <= ST_IGNORE;
                  end
                  default: state_q <= ST_IGNORE;
                endcase
              end
            end
            ST_ADDR: begin
              addr_q <= fourWire ? {addr_q[27:0], ioSync} : {addr_q[30:0], ioSync[0]};
              bitCnt_q <= bitsAfter;
              if (bitsAfter == addrBits) begin
                bitCnt_q <= 6'h00;
                dummyCnt_q <= {2'b00, latency};
                if (latency == 4'h0) begin
                  state_q <= ST_DATA;
                  outByte_q <= paramMem[fourWire ? {addr_q[3:0], ioSync} :
                                                   {addr_q[6:0], ioSync[0]}];
                end else begin
                  state_q <= ST_DUMMY;
                end
              end
            end
            ST_DUMMY: begin
              // lines are not looked at here; they may float
              dummyCnt_q <= dummyCnt_q - 6'h01;
              if (dummyCnt_q == 6'h01) begin
                state_q <= ST_DATA;
                outByte_q <= pickByte(kind_q, 4'h0, addr_q);
              end
            end
            default: ;
          endcase
        end
        if (sckFall && state_q == ST_DATA) begin
          // drive msb first; a new byte is loaded after the last bit or nibble
          ioOe <= quadOut_q ? 4'hF : 4'h2;
          if (quadOut_q) begin
            ioOut <= (outBit_q == 3'h0) ? outByte_q[7:4] : outByte_q[3:0];
            outBit_q <= (outBit_q == 3'h0) ? 3'h4 : 3'h0;
          end else begin
            ioOut <= {2'b00, outByte_q[3'h7 - outBit_q], 1'b0};
            outBit_q <= outBit_q + 3'h1;
          end
          if ((quadOut_q && outBit_q == 3'h4) || (!quadOut_q && outBit_q == 3'h7)) begin
            byteIdx_q <= byteIdx_q + 4'h1;
            addr_q <= addr_q + 32'h00000001;
            if (kind_q == KIND_PARAM) begin
              outByte_q <= paramMem[addr_q[7:0] + 8'h01];
            end else begin
              // status is resampled at each byte boundary
              outByte_q <= pickByte(kind_q, byteIdx_q + 4'h1, addr_q);
            end
          end
        end
      end
      // a set arriving with an exit or soft reset wins
      if (continuousModeSet) begin
        continuousMode <= 1'b1;
      end
    end
  end
endmodule // fidsr_core

/* File: fidsr_chk.sv */
// checker for the flash id and status read block ports
`timescale 1ns/1ps
module fidsr_chk (
  input wire clk,
  input wire rstn,
  input wire csnPin,
  input wire sckPin,
  input wire [3:0] ioOut,
  input wire [3:0] ioOe,
  input wire cfgWrite,
  input wire [7:0] cfgOneIn,
  input wire continuousModeSet,
  input wire [7:0] volatileConfigOne,
  input wire [7:0] volatileConfigTwo,
  input wire [7:0] volatileConfigThree,
  input wire continuousMode,
  input wire softResetPulse,
  input wire protectBitOne,
  input wire lockBit
);
  // ****
  // helper counts, saturating so they never wrap
  // ****
  reg [3:0] hi_q;
  reg [3:0] fall_q;
  reg sck_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_q <= 4'h0;
      fall_q <= 4'hF;
      sck_q <= 1'b0;
    end else begin
      sck_q <= sckPin;
      hi_q <= csnPin ? hi_q + {3'h0, hi_q != 4'hF} : 4'h0;
      fall_q <= (sck_q && !sckPin) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_deselect_quiet: assert property (hi_q >= 4'hA |-> ioOe == 4'h0)
    else $error("io driven while deselected");
  a_oe_shape: assert property (ioOe == 4'h0 || ioOe == 4'h2 || ioOe == 4'hF)
    else $error("bad io enable pattern");
  a_quad_gate: assert property (ioOe == 4'hF |-> volatileConfigTwo[3] || volatileConfigOne[1])
    else $error("quad drive without quad mode");
  a_out_after_fall: assert property ($changed(ioOut) && ioOe != 4'h0 |-> fall_q <= 4'h8)
    else $error("output moved away from a clock fall");
  a_cfg_load: assert property (cfgWrite |=> volatileConfigOne == $past(cfgOneIn))
    else $error("config one not loaded");
  a_reset_dflt: assert property (softResetPulse |-> ##[0:1]
    (volatileConfigThree == 8'h08 && volatileConfigOne == 8'h00 && !continuousMode))
    else $error("soft reset left non-default state");
  a_keep_protect: assert property (softResetPulse |->
    ($stable(protectBitOne) && $stable(lockBit)) [*2])
    else $error("soft reset touched protect or lock");
  a_pulse_single: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset pulse too long");
  a_mode_enter: assert property (continuousModeSet |=> continuousMode)
    else $error("continuous mode not entered");
  c_soft_reset: cover property (softResetPulse);
  c_quad_out: cover property (ioOe == 4'hF);
  c_mode_exit: cover property (continuousMode ##1 !continuousMode);
endmodule // fidsr_chk

bind fidsr_core fidsr_chk u_chk (
  .clk(clk), .rstn(rstn), .csnPin(csnPin), .sckPin(sckPin),
  .ioOut(ioOut), .ioOe(ioOe), .cfgWrite(cfgWrite), .cfgOneIn(cfgOneIn),
  .continuousModeSet(continuousModeSet), .volatileConfigOne(volatileConfigOne),
  .volatileConfigTwo(volatileConfigTwo), .volatileConfigThree(volatileConfigThree),
  .continuousMode(continuousMode), .softResetPulse(softResetPulse),
  .protectBitOne(protectBitOne), .lockBit(lockBit)
);

/* File: fidsr_host.sv */
// spi host model driving the flash block pins
`timescale 1ns/1ps
module fidsr_host (
  input wire clk,
  input wire [3:0] ioOut,
  input wire [3:0] ioOe,
  output reg csnPin,
  output reg sckPin,
  output wire [3:0] ioIn
);
  reg [3:0] drv;
  reg [3:0] hostOe;
  reg flip;
  reg sawOe;
  initial begin
    csnPin = 1'b1;
    sckPin = 1'b0;
    drv = 4'h0;
    hostOe = 4'h0;
    flip = 1'b0;
    sawOe = 1'b0;
  end
  // released lines toggle each cycle so stale data never looks valid
  always @(posedge clk) flip <= ~flip;
  assign ioIn = (ioOe & ioOut) | (~ioOe & ((hostOe & drv) | (~hostOe & {4{flip}})));
  always @(posedge clk) if (!csnPin && ioOe != 4'h0) sawOe <= 1'b1;
  // ****
  // one serial clock: set while low, sample at the rise (mode 0)
  // ****
  task tick(input [3:0] d, input [3:0] oe, output [3:0] s);
    begin
      drv <= d;
      hostOe <= oe;
      repeat (10) @(posedge clk);
      sckPin <= 1'b1;
      s = ioIn;
      repeat (10) @(posedge clk);
      sckPin <= 1'b0;
    end
  endtask
  // clock stands low between frames; 160 ns period keeps under 108 MHz
  task frame(input [7:0] op, input qi, input qo, input [31:0] ad, input [2:0] nab,
    input [5:0] dum, input [6:0] nrd, output [63:0] rd);
    integer k;
    reg [3:0] s;
    reg [39:0] sh;
    begin
      rd = 64'h0;
      sawOe <= 1'b0;
      csnPin <= 1'b0;
      repeat (10) @(posedge clk);
      sh = {op, ad << (8 * (4 - nab))};
      for (k = 0; k < (qi ? 2 + 2 * nab : 8 + 8 * nab); k = k + 1) begin
        tick(qi ? sh[39:36] : {3'h0, sh[39]}, qi ? 4'hF : 4'h1, s);
        sh = qi ? sh << 4 : sh << 1;
      end
      for (k = 0; k < dum; k = k + 1) tick(4'h0, 4'h0, s);
      for (k = 0; k < nrd; k = k + 1) begin
        tick(4'h0, 4'h0, s);
        rd = qo ? {rd[59:0], s} : {rd[62:0], s[1]};
      end
      csnPin <= 1'b1;
      hostOe <= 4'h0;
      repeat (20) @(posedge clk);
    end
  endtask
endmodule // fidsr_host

/* File: testbench.sv */
// self-checking bench for the flash id and status read block
`timescale 1ns/1ps
module testbench;
  localparam [7:0] MK = 8'hC3; // arbitrary value
  localparam [15:0] DV = 16'h7E21; // arbitrary value
  localparam [63:0] UN = 64'h9A3C51E70D48B26F; // arbitrary value
  localparam [47:0] RSV = 48'h1841434AEDEE;
  reg clk, rstn, busy, cfgWrite, cms, p1, lk;
  reg [7:0] s1, s2, c1, c2, c3, a, b;
  wire csnPin, sckPin, cm, srp, pb1, lb;
  wire [3:0] ioIn, ioOut, ioOe;
  wire [7:0] v1, v2, v3;
  integer n_errors, comparisons, seed, k, pulses, rv;
  reg [63:0] r, r2;
  fidsr_core #(.MAKER_ID(MK), .DEVICE_ID(DV), .UNIQUE_NUMBER(UN)) u_fidsr_core (
    .clk(clk), .rstn(rstn), .clkEn(1'b1), .csnPin(csnPin), .sckPin(sckPin),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .busy(busy),
    .volatileStatusOne(s1), .volatileStatusTwo(s2), .protectBitOneIn(p1),
    .lockBitIn(lk), .cfgWrite(cfgWrite), .cfgOneIn(c1), .cfgTwoIn(c2),
    .cfgThreeIn(c3), .continuousModeSet(cms), .volatileConfigOne(v1),
    .volatileConfigTwo(v2), .volatileConfigThree(v3), .continuousMode(cm),
    .softResetPulse(srp), .protectBitOne(pb1), .lockBit(lb));
  fidsr_host u_fidsr_host (.clk(clk), .ioOut(ioOut), .ioOe(ioOe),
    .csnPin(csnPin), .sckPin(sckPin), .ioIn(ioIn));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (srp === 1'b1) pulses <= pulses + 1;
  // ****
  // shared tasks
  // ****
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task setc(input [7:0] x, input [7:0] y, input [7:0] z);
    begin
      c1 <= x;
      c2 <= y;
      c3 <= z;
      cfgWrite <= 1'b1;
      @(posedge clk);
      cfgWrite <= 1'b0;
      @(posedge clk);
    end
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_errors = n_errors + 1;
    end_of_test;
  end
  // ****
  // main sequence
  // ****
  initial begin
    {n_errors, comparisons, pulses} = 96'h0;
    seed = 21544;
    {rstn, busy, cfgWrite, cms, p1, lk, s1, s2, c1, c2} = 38'h0;
    c3 = 8'h08;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({v1, v2, v3, cm, srp}, {16'h0, 8'h08, 2'h0});
    u_fidsr_host.frame(8'h9F, 0, 0, 0, 0, 0, 24, r);
    chk(r, {MK, DV});
    u_fidsr_host.frame(8'h9F, 0, 0, 0, 0, 0, 5, r);
    u_fidsr_host.frame(8'h9F, 0, 0, 0, 0, 0, 24, r);
    chk(r, {MK, DV});
    busy <= 1'b1;
    u_fidsr_host.frame(8'h9F, 0, 0, 0, 0, 0, 8, r);
    chk(u_fidsr_host.sawOe, 0);
    for (k = 0; k < 4; k = k + 1) begin
      rv = $random(seed);
      a = rv[7:0];
      b = rv[15:8];
      busy <= k[1];
      s1 <= a;
      s2 <= a;
      fork
        u_fidsr_host.frame(k[0] ? 8'h07 : 8'h05, 0, 0, 0, 0, 0, 16, r);
        begin
          repeat (250) @(posedge clk);
          s1 <= b;
          s2 <= b;
        end
      join
      chk(r[15:0], {a, b});
    end
    busy <= 1'b0;
    u_fidsr_host.frame(8'hAF, 0, 1, 0, 0, 0, 6, r);
    chk(u_fidsr_host.sawOe, 0);
    setc(8'h02, 8'h00, 8'h08);
    u_fidsr_host.frame(8'hAF, 0, 1, 0, 0, 0, 6, r);
    chk(r, {MK, DV});
    setc(8'h00, 8'h08, 8'h08);
    u_fidsr_host.frame(8'hAF, 1, 1, 0, 0, 0, 6, r);
    chk(r, {MK, DV});
    u_fidsr_host.frame(8'h05, 1, 1, 0, 0, 0, 2, r);
    chk(r, s1);
    u_fidsr_host.frame(8'h07, 1, 1, 0, 0, 0, 2, r);
    chk(u_fidsr_host.sawOe, 0);
    u_fidsr_host.frame(8'h4B, 1, 1, 0, 0, 32, 16, r);
    chk(r, UN);
    setc(8'h00, 8'h00, 8'h08);
    u_fidsr_host.frame(8'h4B, 0, 0, 0, 0, 32, 64, r);
    chk(r, UN);
    for (k = 0; k < 4; k = k + 1) begin
      rv = $random(seed);
      a = rv[7:0];
      b = (k == 0) ? 8'h00 : {4'h0, rv[11:8]};
      setc(8'h00, {7'h00, k[0]}, 8'h08);
      u_fidsr_host.frame(8'h5A, 0, 0, {24'h000000, a}, k[0] ? 3'h4 : 3'h3, 8, 16, r);
      setc(8'h00, {7'h00, k[0]}, b);
      u_fidsr_host.frame(8'h5A, 0, 0, {24'h000000, a + 8'h01}, k[0] ? 3'h4 : 3'h3,
        b[5:0], 8, r2);
      chk(r2[7:0], r[7:0]);
    end
    cms <= 1'b1;
    @(posedge clk);
    cms <= 1'b0;
    @(posedge clk);
    chk(cm, 1);
    u_fidsr_host.frame(8'hFF, 0, 0, 0, 0, 0, 0, r);
    chk(cm, 0);
    p1 <= 1'b1;
    lk <= 1'b1;
    setc(8'h02, 8'h01, 8'h05);
    for (k = 0; k < 6; k = k + 1) begin
      u_fidsr_host.frame(RSV[47 - 8 * k -: 8], 0, 0, 0, 0, 0, 0, r);
      chk({v1, v2, v3, pulses[7:0]}, 32'h02010500);
    end
    u_fidsr_host.frame(8'h66, 0, 0, 0, 0, 0, 0, r);
    u_fidsr_host.frame(8'h05, 0, 0, 0, 0, 0, 8, r);
    u_fidsr_host.frame(8'h99, 0, 0, 0, 0, 0, 0, r);
    chk(pulses, 0);
    u_fidsr_host.frame(8'h66, 0, 0, 0, 0, 0, 0, r);
    u_fidsr_host.frame(8'h99, 0, 0, 0, 0, 0, 0, r);
    chk({v1, v2, v3, pb1, lb, pulses[3:0]}, {24'h000008, 6'h31});
    end_of_test;
  end
endmodule // testbench
